// ==== hw/rsx_pkg.sv ====
package rsx_pkg;

    // ---------------------------------------------------------------
    // widths and reset values
    // ---------------------------------------------------------------
    localparam int        DATA_W    = 8;
    localparam int        PC_W      = 12;
    localparam logic [7:0] ACC_RST  = 8'h00;
    localparam logic [7:0] ONE      = 8'h01;
    localparam logic      GIE_RST   = 1'b0;

    // ---------------------------------------------------------------
    // operations handled by this datapath
    // ---------------------------------------------------------------
    typedef enum logic [4:0] {
        idle_op,
        copy_imm_op,
        copy_to_mem_op,
        or_mem_op,
        or_imm_op,
        union_into_memory,
        subroutine_exit,
        subroutine_exit_imm,
        interrupt_exit,
        rotate_left_mem,
        rotate_left_acc_dest,
        rotate_left_carry_mem,
        rotate_left_carry_acc_dest,
        rotate_right_mem,
        rotate_right_acc_dest,
        rotate_right_via_flag_mem,
        rotate_right_via_flag_acc_dest,
        subtract_with_borrow_acc,
        subtract_with_borrow_mem,
        decrement_skip_zero_mem,
        decrement_skip_zero_acc
    } rsx_op_t;

    typedef struct packed {
        rsx_op_t    op;
        logic [7:0] imm;
    } rsx_ins_t;

    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } rsx_flags_t;

    localparam rsx_flags_t FLAGS_RST = '{ov: 1'b0, z: 1'b0, ac: 1'b0,
                                         c: 1'b0};

    typedef enum logic {
        st_exec,
        st_dummy
    } rsx_state_t;

endpackage

// ==== hw/rsx_exec.sv ====
`timescale 1ns/1ps

// What this block does
// [RULE_01] immediate copy loads accumulator, flags kept
// [RULE_02] accumulator copied to addressed memory
// [RULE_03] idle only advances program counter
// [RULE_04] or with memory or immediate
// [RULE_05] subroutine exit reloads pc, two cycles
// [RULE_06] exit with constant also loads accumulator
// [RULE_07] interrupt exit reloads pc, enables interrupts
// [RULE_08] rotate memory left, write memory
// [RULE_09] rotate memory left into accumulator
// [RULE_10] rotate left through carry, write memory
// [RULE_11] rotate left through carry into accumulator
// [RULE_12] rotate memory right, write memory
// [RULE_13] rotate memory right into accumulator
// [RULE_14] rotate right through carry, write memory
// [RULE_15] rotate right through carry into accumulator
// [RULE_16] subtract memory and borrow into accumulator
// [RULE_17] subtract memory and borrow into memory
// [RULE_18] decrement memory, skip next when zero
// [RULE_19] decrement into accumulator, skip when zero
// [RULE_20] or sets zero, carry rotates set carry
// [RULE_21] subtraction updates ov, z, ac, c
// [RULE_22] decrement and skip keep all flags
module rsx_exec (
    // clock, reset, enable
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    // instruction issue
    input  wire logic                    ins_valid,
    input  wire rsx_pkg::rsx_ins_t       ins,
    output logic                         ready,
    // data memory and return stack
    input  wire logic [7:0]              mem_rdata,
    input  wire logic [rsx_pkg::PC_W-1:0] stack_top,
    output logic                         mem_we,
    output logic [7:0]                   mem_wdata,
    // sequencing
    output logic                         pc_inc,
    output logic                         pc_load,
    output logic [rsx_pkg::PC_W-1:0]     pc_value,
    output logic                         stack_pop,
    output logic                         skip,
    // architectural state
    output logic [7:0]                   acc,
    output rsx_pkg::rsx_flags_t          flags,
    output logic                         global_interrupt_enable
);
    import rsx_pkg::*;

    // ---------------------------------------------------------------
    // result computation
    // ---------------------------------------------------------------
    rsx_state_t  state;
    logic        take;
    logic [7:0]  res;
    logic        res_to_acc;
    logic        res_to_mem;
    rsx_flags_t  next_flags;
    logic [8:0]  diff;
    logic [4:0]  diff_lo;
    logic [7:0]  dec;
    logic        is_exit;
    logic        do_skip;

    assign take    = ce && ins_valid && (state == st_exec);
    assign dec     = mem_rdata - ONE;
    assign diff    = {1'b0, acc} + {1'b0, ~mem_rdata} + {8'h00, flags.c};
    assign diff_lo = {1'b0, acc[3:0]} + {1'b0, ~mem_rdata[3:0]}
                   + {4'h0, flags.c};

    always_comb begin
        res        = mem_rdata;
        res_to_acc = 1'b0;
        res_to_mem = 1'b0;
        next_flags = flags;
        is_exit    = 1'b0;
        do_skip    = 1'b0;
        unique case (ins.op)
            idle_op: begin
            end
            copy_imm_op: begin
                res        = ins.imm; // RULE_01
                res_to_acc = 1'b1;
            end
            copy_to_mem_op: begin
                res        = acc; // RULE_02
                res_to_mem = 1'b1;
            end
            or_mem_op, or_imm_op, union_into_memory: begin
                res          = acc | ((ins.op == or_imm_op) ? ins.imm
                                                            : mem_rdata);
                res_to_acc   = (ins.op != union_into_memory); // RULE_04
                res_to_mem   = (ins.op == union_into_memory);
                next_flags.z = (res == 8'h00); // RULE_20
            end
            subroutine_exit: begin
                is_exit = 1'b1; // RULE_05
            end
            subroutine_exit_imm: begin
                is_exit    = 1'b1;
                res        = ins.imm; // RULE_06
                res_to_acc = 1'b1;
            end
            interrupt_exit: begin
                is_exit = 1'b1; // RULE_07
            end
            rotate_left_mem, rotate_left_acc_dest: begin
                res        = {mem_rdata[6:0], mem_rdata[7]}; // RULE_08
                res_to_mem = (ins.op == rotate_left_mem);
                res_to_acc = (ins.op == rotate_left_acc_dest); // RULE_09
            end
            rotate_left_carry_mem, rotate_left_carry_acc_dest: begin
                res          = {mem_rdata[6:0], flags.c}; // RULE_10
                next_flags.c = mem_rdata[7]; // RULE_20
                res_to_mem   = (ins.op == rotate_left_carry_mem);
                res_to_acc   = (ins.op ==
                                rotate_left_carry_acc_dest); // RULE_11
            end
            rotate_right_mem, rotate_right_acc_dest: begin
                res        = {mem_rdata[0], mem_rdata[7:1]}; // RULE_12
                res_to_mem = (ins.op == rotate_right_mem);
                res_to_acc = (ins.op == rotate_right_acc_dest); // RULE_13
            end
            rotate_right_via_flag_mem, rotate_right_via_flag_acc_dest: begin
                res          = {flags.c, mem_rdata[7:1]}; // RULE_14
                next_flags.c = mem_rdata[0];
                res_to_mem   = (ins.op == rotate_right_via_flag_mem);
                res_to_acc   = (ins.op ==
                                rotate_right_via_flag_acc_dest); // RULE_15
            end
            subtract_with_borrow_acc, subtract_with_borrow_mem: begin
                res           = diff[7:0]; // RULE_16
                res_to_acc    = (ins.op == subtract_with_borrow_acc);
                res_to_mem    = (ins.op == subtract_with_borrow_mem); // RULE_17
                next_flags.c  = diff[8]; // RULE_21
                next_flags.ac = diff_lo[4];
                next_flags.z  = (diff[7:0] == 8'h00);
                next_flags.ov = (acc[7] != mem_rdata[7])
                             && (diff[7] != acc[7]);
            end
            decrement_skip_zero_mem, decrement_skip_zero_acc: begin
                res        = dec; // RULE_22
                do_skip    = (dec == 8'h00); // RULE_18
                res_to_mem = (ins.op == decrement_skip_zero_mem);
                res_to_acc = (ins.op == decrement_skip_zero_acc); // RULE_19
            end
        endcase
    end

    // ---------------------------------------------------------------
    // sequencing: dummy cycle after exits and taken skips
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= st_exec;
            ready <= 1'b1;
        end else if (ce) begin
            if (state == st_dummy) begin
                state <= st_exec;
                ready <= 1'b1;
            end else if (take && (is_exit || do_skip)) begin
                state <= st_dummy; // RULE_05
                ready <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pc_inc    <= 1'b0;
            pc_load   <= 1'b0;
            pc_value  <= '0;
            stack_pop <= 1'b0;
            skip      <= 1'b0;
        end else if (ce) begin
            pc_inc    <= take && !is_exit; // RULE_03
            pc_load   <= take && is_exit;
            stack_pop <= take && is_exit;
            skip      <= take && do_skip; // RULE_18
            if (take && is_exit) begin
                pc_value <= stack_top;
            end
        end
    end

    // ---------------------------------------------------------------
    // accumulator, flags, memory write, interrupt enable
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc <= ACC_RST;
        end else if (take && res_to_acc) begin
            acc <= res;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags <= FLAGS_RST;
        end else if (take) begin
            flags <= next_flags;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem_we    <= 1'b0;
            mem_wdata <= 8'h00;
        end else if (ce) begin
            mem_we <= take && res_to_mem;
            if (take && res_to_mem) begin
                mem_wdata <= res;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            global_interrupt_enable <= GIE_RST;
        end else if (take && ins.op == interrupt_exit) begin
            global_interrupt_enable <= 1'b1; // RULE_07
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_take_op(rsx_op_t o);
        take && ins.op == o;
    endsequence

    property p_copy_imm;
        @(posedge clk) disable iff (!rst_n)
        s_take_op(copy_imm_op) |=> acc == $past(ins.imm)
            && flags == $past(flags);
    endproperty
    a_copy_imm: assert property (p_copy_imm) // RULE_01
        else $error("immediate copy wrong");

    property p_copy_mem;
        @(posedge clk) disable iff (!rst_n)
        s_take_op(copy_to_mem_op) |=> mem_we && mem_wdata == $past(acc);
    endproperty
    a_copy_mem: assert property (p_copy_mem) // RULE_02
        else $error("store of accumulator wrong");

    property p_idle;
        @(posedge clk) disable iff (!rst_n)
        s_take_op(idle_op) |=> pc_inc && !mem_we && !pc_load
            && acc == $past(acc);
    endproperty
    a_idle: assert property (p_idle) // RULE_03
        else $error("idle changed state");

    property p_or_zero;
        @(posedge clk) disable iff (!rst_n)
        s_take_op(or_imm_op) |=> acc == ($past(acc) | $past(ins.imm))
            && flags.z == (acc == 8'h00) && flags.c == $past(flags.c);
    endproperty
    a_or_zero: assert property (p_or_zero) // RULE_04
        else $error("or result or zero flag wrong");

    sequence s_exit_dummy;
        pc_load && !ready ##1 !pc_inc;
    endsequence

    property p_exit;
        @(posedge clk) disable iff (!rst_n)
        s_take_op(subroutine_exit) |=> s_exit_dummy
            and (pc_value == $past(stack_top));
    endproperty
    a_exit: assert property (p_exit) // RULE_05
        else $error("subroutine exit sequencing wrong");

    property p_int_exit;
        @(posedge clk) disable iff (!rst_n)
        s_take_op(interrupt_exit) |=> global_interrupt_enable && pc_load;
    endproperty
    a_int_exit: assert property (p_int_exit) // RULE_07
        else $error("interrupt enable not set");

    property p_rotl;
        @(posedge clk) disable iff (!rst_n)
        s_take_op(rotate_left_mem) |=> mem_we
            && mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])};
    endproperty
    a_rotl: assert property (p_rotl) // RULE_08
        else $error("left rotate wrong");

    property p_rotr_carry;
        @(posedge clk) disable iff (!rst_n)
        s_take_op(rotate_right_via_flag_acc_dest) |=> !mem_we
            && acc == {$past(flags.c), $past(mem_rdata[7:1])}
            && flags.c == $past(mem_rdata[0]);
    endproperty
    a_rotr_carry: assert property (p_rotr_carry) // RULE_15
        else $error("right rotate through carry wrong");

    property p_sub;
        @(posedge clk) disable iff (!rst_n)
        s_take_op(subtract_with_borrow_acc) |=>
            {flags.c, acc} == {1'b0, $past(acc)} + {1'b0, ~$past(mem_rdata)}
                + {8'h00, $past(flags.c)};
    endproperty
    a_sub: assert property (p_sub) // RULE_16
        else $error("subtract with borrow wrong");

    property p_skip;
        @(posedge clk) disable iff (!rst_n)
        take && ins.op == decrement_skip_zero_mem && mem_rdata == ONE |=>
            skip && !ready && mem_wdata == 8'h00 && flags == $past(flags);
    endproperty
    a_skip: assert property (p_skip) // RULE_18
        else $error("decrement skip wrong");

    property p_exit_imm;
        @(posedge clk) disable iff (!rst_n)
        s_take_op(subroutine_exit_imm) |=> pc_load && stack_pop
            && acc == $past(ins.imm) && pc_value == $past(stack_top);
    endproperty
    a_exit_imm: assert property (p_exit_imm) // RULE_06
        else $error("exit with constant wrong");

    property p_rotl_carry;
        @(posedge clk) disable iff (!rst_n)
        s_take_op(rotate_left_carry_mem) |=> mem_we
            && mem_wdata == {$past(mem_rdata[6:0]), $past(flags.c)}
            && flags.c == $past(mem_rdata[7]);
    endproperty
    a_rotl_carry: assert property (p_rotl_carry) // RULE_10
        else $error("left rotate through carry wrong");

    property p_rotr_acc;
        @(posedge clk) disable iff (!rst_n)
        s_take_op(rotate_right_acc_dest) |=> !mem_we
            && acc == {$past(mem_rdata[0]), $past(mem_rdata[7:1])}
            && flags == $past(flags);
    endproperty
    a_rotr_acc: assert property (p_rotr_acc) // RULE_13
        else $error("right rotate into accumulator wrong");

    property p_sub_mem;
        @(posedge clk) disable iff (!rst_n)
        s_take_op(subtract_with_borrow_mem) |=> mem_we
            && {flags.c, mem_wdata} == {1'b0, $past(acc)}
                + {1'b0, ~$past(mem_rdata)} + {8'h00, $past(flags.c)}
            && flags.z == (mem_wdata == 8'h00) && acc == $past(acc);
    endproperty
    a_sub_mem: assert property (p_sub_mem) // RULE_17
        else $error("subtract with borrow into memory wrong");

    property p_skip_acc;
        @(posedge clk) disable iff (!rst_n)
        take && ins.op == decrement_skip_zero_acc && mem_rdata == ONE |=>
            skip && !ready && acc == 8'h00 && !mem_we
            && flags == $past(flags);
    endproperty
    a_skip_acc: assert property (p_skip_acc) // RULE_19
        else $error("decrement into accumulator skip wrong");

endmodule

// ==== testbench/rsx_exec_tb.sv ====
`timescale 1ns/1ps

module rsx_exec_tb;
    import rsx_pkg::*;

    // ---------------------------------------------------------------
    // design hookup
    // ---------------------------------------------------------------
    logic        clk;
    logic        rst_n;
    logic        ce;
    logic        ins_valid;
    rsx_ins_t    ins;
    logic        ready;
    logic [7:0]  mem_rdata;
    logic [11:0] stack_top;
    logic        mem_we;
    logic [7:0]  mem_wdata;
    logic        pc_inc;
    logic        pc_load;
    logic [11:0] pc_value;
    logic        stack_pop;
    logic        skip;
    logic [7:0]  acc;
    rsx_flags_t  flags;
    logic        gie;
    int          errors;
    int          n_compared;
    int          cycles;
    logic [15:0] rnd;
    logic [7:0]  a;
    rsx_flags_t  f;
    logic        g;
    logic [7:0]  w;

    rsx_exec dut_u (.clk(clk), .rst_n(rst_n), .ce(ce),
        .ins_valid(ins_valid), .ins(ins), .ready(ready),
        .mem_rdata(mem_rdata), .stack_top(stack_top), .mem_we(mem_we),
        .mem_wdata(mem_wdata), .pc_inc(pc_inc), .pc_load(pc_load),
        .pc_value(pc_value), .stack_pop(stack_pop), .skip(skip),
        .acc(acc), .flags(flags), .global_interrupt_enable(gie));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // checking helpers
    // ---------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic cmp_bit(input string nm, input logic e, input logic s);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s expected %b seen %b", nm, e, s);
        end
    endtask

    task automatic cmp_word(input string nm, input logic [11:0] e,
                            input logic [11:0] s);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            errors++;
            stop_test();
        end
    end

    // ---------------------------------------------------------------
    // one instruction with expected results
    // ---------------------------------------------------------------
    task automatic run_op(input rsx_op_t op, input logic [7:0] imm,
                          input logic [7:0] m, input logic [11:0] st,
                          input logic poke);
        logic       e_we;
        logic       e_inc;
        logic       e_ld;
        logic       e_sk;
        logic [8:0] r9;
        logic [4:0] r5;
        e_we = 1'b0;
        e_inc = 1'b1;
        e_ld = 1'b0;
        e_sk = 1'b0;
        r9 = {1'b0, a} + {1'b0, ~m} + {8'h00, f.c};
        r5 = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + {4'h0, f.c};
        case (op)
            copy_imm_op:         a = imm;
            copy_to_mem_op:      {e_we, w} = {1'b1, a};
            or_mem_op:           {a, f.z} = {a | m, (a | m) == 8'h00};
            or_imm_op:           {a, f.z} = {a | imm, (a | imm) == 8'h00};
            union_into_memory:   {e_we, w, f.z} = {1'b1, a | m,
                                                   (a | m) == 8'h00};
            subroutine_exit:     {e_inc, e_ld} = 2'b01;
            subroutine_exit_imm: {e_inc, e_ld, a} = {2'b01, imm};
            interrupt_exit:      {e_inc, e_ld, g} = 3'b011;
            rotate_left_mem:     {e_we, w} = {1'b1, m[6:0], m[7]};
            rotate_left_acc_dest: a = {m[6:0], m[7]};
            rotate_left_carry_mem: {e_we, w, f.c} = {1'b1, m[6:0], f.c, m[7]};
            rotate_left_carry_acc_dest: {a, f.c} = {m[6:0], f.c, m[7]};
            rotate_right_mem:    {e_we, w} = {1'b1, m[0], m[7:1]};
            rotate_right_acc_dest: a = {m[0], m[7:1]};
            rotate_right_via_flag_mem: {e_we, w, f.c} = {1'b1, f.c, m};
            rotate_right_via_flag_acc_dest: {a, f.c} = {f.c, m};
            subtract_with_borrow_acc, subtract_with_borrow_mem: begin
                f.ov = (a[7] ^ m[7]) & (r9[7] ^ a[7]);
                f.z = (r9[7:0] == 8'h00);
                f.ac = r5[4];
                f.c = r9[8];
                if (op == subtract_with_borrow_acc)
                    a = r9[7:0];
                else
                    {e_we, w} = {1'b1, r9[7:0]};
            end
            decrement_skip_zero_mem: {e_we, w, e_sk} = {1'b1, m - 8'h01,
                                                        m == 8'h01};
            decrement_skip_zero_acc: {a, e_sk} = {m - 8'h01, m == 8'h01};
            default: ;
        endcase
        ins_valid = 1'b1;
        ins = '{op: op, imm: imm};
        mem_rdata = m;
        stack_top = st;
        @(posedge clk);
        @(negedge clk);
        cmp_word("acc", a, acc);
        cmp_word("flags", f, flags);
        cmp_bit("gie", g, gie);
        cmp_bit("mem_we", e_we, mem_we);
        cmp_word("mem_wdata", w, mem_wdata);
        cmp_bit("pc_inc", e_inc, pc_inc);
        cmp_bit("pc_load", e_ld, pc_load);
        cmp_bit("stack_pop", e_ld, stack_pop);
        cmp_bit("skip", e_sk, skip);
        cmp_bit("ready", !(e_ld | e_sk), ready);
        if (e_ld)
            cmp_word("pc_value", st, pc_value);
        if (e_ld | e_sk) begin
            ins_valid = poke;
            ins = '{op: copy_imm_op, imm: ~a};
            @(posedge clk);
            @(negedge clk);
            cmp_word("acc", a, acc);
            cmp_bit("ready", 1'b1, ready);
            cmp_bit("pc_load", 1'b0, pc_load);
        end
    endtask

    task automatic reset_model;
        a = ACC_RST;
        f = FLAGS_RST;
        g = GIE_RST;
        w = 8'h00;
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        errors = 0;
        n_compared = 0;
        cycles = 0;
        rnd = 16'h0047;
        rst_n = 1'b0;
        ce = 1'b1;
        ins_valid = 1'b0;
        ins = '{op: idle_op, imm: 8'h00};
        mem_rdata = 8'h00;
        stack_top = 12'h000;
        reset_model();
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        cmp_bit("ready", 1'b1, ready);
        cmp_word("acc", ACC_RST, acc);
        // every operation, zero and non-zero decrement results
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 21; i++) begin
                run_op(rsx_op_t'(i), 8'h5A, p ? 8'h01 : 8'h81, 12'hA5C, 1'b1);
            end
        end
        run_op(or_imm_op, 8'h00, 8'h00, 12'h000, 1'b0);
        $display("test directed done");
        // random instruction stream
        for (int i = 0; i < 600; i++) begin
            rnd = lfsr(rnd);
            rnd = lfsr(rnd);
            run_op(rsx_op_t'(rnd % 21), rnd[15:8], rnd[12:5],
                   {rnd[3:0], rnd[15:8]}, rnd[7]);
        end
        $display("test random done");
        // clock enable low freezes the accumulator
        ce = 1'b0;
        ins_valid = 1'b1;
        ins = '{op: copy_imm_op, imm: ~a};
        @(posedge clk);
        @(negedge clk);
        cmp_word("acc", a, acc);
        ce = 1'b1;
        run_op(copy_imm_op, 8'hC3, 8'h00, 12'h000, 1'b0);
        $display("test enable done");
        // reset in mid-run
        @(negedge clk);
        rst_n = 1'b0;
        @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        reset_model();
        cmp_word("acc", a, acc);
        cmp_bit("gie", g, gie);
        cmp_bit("pc_inc", 1'b0, pc_inc);
        run_op(interrupt_exit, 8'h00, 8'h00, 12'hFFF, 1'b1);
        $display("test reset done");
        stop_test();
    end
endmodule
